// [ppm_pkg.sv]
// constants for the port pin mode and alternate function block
`default_nettype none
package ppm_pkg;

  // =====================================================
  // register addresses
  localparam logic [7:0] PPM_ADDR_P1_MODE_LOW  = 8'hAE;
  localparam logic [7:0] PPM_ADDR_P1_MODE_HIGH = 8'hAF;
  localparam logic [7:0] PPM_ADDR_P3_LATCH     = 8'hB0;
  localparam logic [7:0] PPM_ADDR_P2_MODE_LOW  = 8'hB1;
  localparam logic [7:0] PPM_ADDR_P2_MODE_HIGH = 8'hB2;

  // =====================================================
  // reset values
  localparam logic [7:0] PPM_MODE_RESET  = 8'h00;
  localparam logic [7:0] PPM_LATCH_RESET = 8'hFF;

  // =====================================================
  // pin mode codes and field positions
  localparam logic [1:0] PPM_MODE_PULLUP = 2'h0;
  localparam logic [1:0] PPM_MODE_PUSH   = 2'h1;
  localparam logic [1:0] PPM_MODE_OPEN   = 2'h2;
  localparam logic [1:0] PPM_MODE_INPUT  = 2'h3;
  localparam int PPM_HCR_MEM_BIT = 1;
  localparam int PPM_BIT_RD      = 7;
  localparam int PPM_BIT_WR      = 6;
  localparam int PPM_BIT_T1      = 5;
  localparam int PPM_BIT_T0      = 4;
  localparam int PPM_BIT_EXTERNAL_IRQ_ONE    = 3;
  localparam int PPM_BIT_EXTERNAL_IRQ_ZERO    = 2;
  localparam int PPM_BIT_TX      = 1;
  localparam int PPM_BIT_RX      = 0;

endpackage
`default_nettype wire

// [ppm_port_ctrl.sv]
// port pin mode, port3 latch and alternate function steering
`default_nettype none
`timescale 1ns/100ps
module ppm_port_ctrl
  import ppm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // special function register access
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_rd,
  output var  logic [7:0]       sfr_rdata_q,
  output var  logic             sfr_hit_q,
  // core-side data and configuration
  input  wire logic [WIDTH-1:0] port1_data,
  input  wire logic [WIDTH-1:0] port2_data,
  input  wire logic [15:0]      port3_mode_cfg,
  input  wire logic [7:0]       hardware_config_one,
  input  wire logic [WIDTH-1:0] ext_addr_high,
  input  wire logic             ext_rd_strobe_b,
  input  wire logic             ext_wr_strobe_b,
  // timer, interrupt and serial peers
  input  wire logic             timer_one_ext_en,
  input  wire logic             timer_zero_ext_en,
  input  wire logic             irq_one_en,
  input  wire logic             irq_one_edge_mode,
  input  wire logic             irq_zero_en,
  input  wire logic             irq_zero_edge_mode,
  input  wire logic             uart0_mode0,
  input  wire logic             uart0_tx_data,
  input  wire logic             uart0_shift_clk,
  input  wire logic             uart0_rx_drive,
  output var  logic             timer_one_count_input,
  output var  logic             timer_zero_count_input,
  output var  logic             external_irq_one,
  output var  logic             external_irq_zero,
  output var  logic             uart0_rx_pin,
  // pins
  input  wire logic             ext_program_select_pin_b,
  input  wire logic [WIDTH-1:0] port1_pin_in,
  input  wire logic [WIDTH-1:0] port2_pin_in,
  input  wire logic [WIDTH-1:0] port3_pin_in,
  output var  logic [WIDTH-1:0] port1_pin_out_q,
  output var  logic [WIDTH-1:0] port1_pin_oe_q,
  output var  logic [WIDTH-1:0] port1_pull_q,
  output var  logic [WIDTH-1:0] port2_pin_out_q,
  output var  logic [WIDTH-1:0] port2_pin_oe_q,
  output var  logic [WIDTH-1:0] port2_pull_q,
  output var  logic [WIDTH-1:0] port3_pin_out_q,
  output var  logic [WIDTH-1:0] port3_pin_oe_q,
  output var  logic [WIDTH-1:0] port3_pull_q,
  output var  logic [WIDTH-1:0] port1_level_q,
  output var  logic [WIDTH-1:0] port2_level_q
);

  // =====================================================
  // mode and latch registers
  logic [7:0]       p1_mode_low_q;
  logic [7:0]       p1_mode_high_q;
  logic [7:0]       p2_mode_low_q;
  logic [7:0]       p2_mode_high_q;
  logic [WIDTH-1:0] p3_latch_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      p1_mode_low_q  <= PPM_MODE_RESET;
      p1_mode_high_q <= PPM_MODE_RESET;
      p2_mode_low_q  <= PPM_MODE_RESET;
      p2_mode_high_q <= PPM_MODE_RESET;
      p3_latch_q     <= WIDTH'(PPM_LATCH_RESET);
    end else if (sfr_wr) begin
      case (sfr_addr)
        PPM_ADDR_P1_MODE_LOW:  p1_mode_low_q  <= sfr_wdata;
        PPM_ADDR_P1_MODE_HIGH: p1_mode_high_q <= sfr_wdata;
        PPM_ADDR_P2_MODE_LOW:  p2_mode_low_q  <= sfr_wdata;
        PPM_ADDR_P2_MODE_HIGH: p2_mode_high_q <= sfr_wdata;
        PPM_ADDR_P3_LATCH:     p3_latch_q     <= sfr_wdata[WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // =====================================================
  // pin synchronisers
  logic [WIDTH-1:0] p1_meta_q;
  logic [WIDTH-1:0] p2_meta_q;
  logic [WIDTH-1:0] p3_meta_q;
  logic [WIDTH-1:0] p3_sync_q;
  logic [WIDTH-1:0] p3_prev_q;
  logic [1:0]       ea_sync_q;

  // pins are asynchronous; reset values are the idle-high levels
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      p1_meta_q     <= '1;
      p2_meta_q     <= '1;
      p3_meta_q     <= '1;
      port1_level_q <= '1;
      port2_level_q <= '1;
      p3_sync_q     <= '1;
      p3_prev_q     <= '1;
    end else begin
      p1_meta_q     <= port1_pin_in;
      p2_meta_q     <= port2_pin_in;
      p3_meta_q     <= port3_pin_in;
      port1_level_q <= p1_meta_q;
      port2_level_q <= p2_meta_q;
      p3_sync_q     <= p3_meta_q;
      p3_prev_q     <= p3_sync_q;
    end
  end

  // a released program-select pin means internal memory, so reset to high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ea_sync_q <= 2'h3;
    end else begin
      ea_sync_q <= {ea_sync_q[0], ext_program_select_pin_b};
    end
  end

  // =====================================================
  // register read path
  logic [7:0] rdata_d;
  logic       hit_d;

  always_comb begin
    hit_d   = 1'b1;
    rdata_d = 8'h00;
    case (sfr_addr)
      PPM_ADDR_P1_MODE_LOW:  rdata_d = p1_mode_low_q;
      PPM_ADDR_P1_MODE_HIGH: rdata_d = p1_mode_high_q;
      PPM_ADDR_P2_MODE_LOW:  rdata_d = p2_mode_low_q;
      PPM_ADDR_P2_MODE_HIGH: rdata_d = p2_mode_high_q;
      PPM_ADDR_P3_LATCH:     rdata_d = 8'(p3_sync_q);
      default:               hit_d   = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end else begin
      sfr_rdata_q <= sfr_rd ? rdata_d : 8'h00;
      sfr_hit_q   <= sfr_rd & hit_d;
    end
  end

  // =====================================================
  // external memory and alternate function values
  logic             ext_mem;
  logic [WIDTH-1:0] p3_alt;
  logic [WIDTH-1:0] p3_data;
  logic [15:0]      p3_mode_eff;

  // program-select pin low or the config bit hands ports to external memory
  assign ext_mem = ~ea_sync_q[1] | hardware_config_one[PPM_HCR_MEM_BIT];

  always_comb begin
    p3_alt = '1;  // inputs-only functions leave the pin released high
    p3_alt[PPM_BIT_RD] = ext_rd_strobe_b;
    p3_alt[PPM_BIT_WR] = ext_wr_strobe_b;
    p3_alt[PPM_BIT_TX] = uart0_mode0 ? uart0_shift_clk : uart0_tx_data;
    p3_alt[PPM_BIT_RX] = uart0_mode0 ? uart0_rx_drive : 1'b1;
    // latch zero pins the output low, latch one lets the function through
    p3_data = p3_latch_q & p3_alt;
    p3_mode_eff = port3_mode_cfg;
    if (ext_mem) begin
      // strobes bypass the latch and the configured modes
      p3_data[PPM_BIT_RD] = ext_rd_strobe_b;
      p3_data[PPM_BIT_WR] = ext_wr_strobe_b;
      p3_mode_eff[2*PPM_BIT_RD +: 2] = PPM_MODE_PUSH;
      p3_mode_eff[2*PPM_BIT_WR +: 2] = PPM_MODE_PUSH;
    end
  end

  // =====================================================
  // per-pin drive decode
  logic [15:0]      p1_mode;
  logic [15:0]      p2_mode;
  logic [WIDTH-1:0] p2_data;
  logic [WIDTH-1:0] p1_oe_d;
  logic [WIDTH-1:0] p1_pull_d;
  logic [WIDTH-1:0] p2_oe_d;
  logic [WIDTH-1:0] p2_pull_d;
  logic [WIDTH-1:0] p3_oe_d;
  logic [WIDTH-1:0] p3_pull_d;

  assign p1_mode = {p1_mode_high_q, p1_mode_low_q};
  assign p2_mode = ext_mem ? {8{PPM_MODE_PUSH}} : {p2_mode_high_q, p2_mode_low_q};
  assign p2_data = ext_mem ? ext_addr_high : port2_data;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      logic [1:0] p1_field;
      logic [1:0] p2_field;
      logic [1:0] p3_field;
      logic       p1_sink;
      logic       p2_sink;
      logic       p3_sink;

      assign p1_field = p1_mode[2*gi +: 2];
      assign p2_field = p2_mode[2*gi +: 2];
      assign p3_field = p3_mode_eff[2*gi +: 2];

      // quasi and open-drain only sink; the weak pull-up is quasi only
      assign p1_sink = (p1_field == PPM_MODE_PULLUP) | (p1_field == PPM_MODE_OPEN);
      assign p2_sink = (p2_field == PPM_MODE_PULLUP) | (p2_field == PPM_MODE_OPEN);
      assign p3_sink = (p3_field == PPM_MODE_PULLUP) | (p3_field == PPM_MODE_OPEN);

      assign p1_oe_d[gi]   = (p1_sink & ~port1_data[gi]) | (p1_field == PPM_MODE_PUSH);
      assign p1_pull_d[gi] = (p1_field == PPM_MODE_PULLUP);
      assign p2_oe_d[gi]   = (p2_sink & ~p2_data[gi]) | (p2_field == PPM_MODE_PUSH);
      assign p2_pull_d[gi] = (p2_field == PPM_MODE_PULLUP);
      assign p3_oe_d[gi]   = (p3_sink & ~p3_data[gi]) | (p3_field == PPM_MODE_PUSH);
      assign p3_pull_d[gi] = (p3_field == PPM_MODE_PULLUP);
    end
  endgenerate

  // input mode keeps oe low so the pin value is never used
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port1_pin_out_q <= '1;
      port1_pin_oe_q  <= '0;
      port1_pull_q    <= '1;
    end else begin
      port1_pin_out_q <= port1_data;
      port1_pin_oe_q  <= p1_oe_d;
      port1_pull_q    <= p1_pull_d;
    end
  end

  // port2 carries the address byte whenever external memory owns it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port2_pin_out_q <= '1;
      port2_pin_oe_q  <= '0;
      port2_pull_q    <= '1;
    end else begin
      port2_pin_out_q <= p2_data;
      port2_pin_oe_q  <= p2_oe_d;
      port2_pull_q    <= p2_pull_d;
    end
  end

  // port3 registers the latch and alternate values after steering
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port3_pin_out_q <= '1;
      port3_pin_oe_q  <= '0;
      port3_pull_q    <= '1;
    end else begin
      port3_pin_out_q <= p3_data;
      port3_pin_oe_q  <= p3_oe_d;
      port3_pull_q    <= p3_pull_d;
    end
  end

  // =====================================================
  // counter, interrupt and receive inputs
  logic [WIDTH-1:0] p3_fall;

  // edge taken on synchronised levels, one cycle after the second stage
  assign p3_fall = p3_prev_q & ~p3_sync_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_one_count_input  <= 1'b0;
      timer_zero_count_input <= 1'b0;
      external_irq_one       <= 1'b0;
      external_irq_zero      <= 1'b0;
      uart0_rx_pin           <= 1'b1;
    end else begin
      timer_one_count_input  <= timer_one_ext_en & p3_fall[PPM_BIT_T1];
      timer_zero_count_input <= timer_zero_ext_en & p3_fall[PPM_BIT_T0];
      external_irq_one  <= irq_one_en & (irq_one_edge_mode ? p3_fall[PPM_BIT_EXTERNAL_IRQ_ONE]
                                                          : ~p3_sync_q[PPM_BIT_EXTERNAL_IRQ_ONE]);
      external_irq_zero <= irq_zero_en & (irq_zero_edge_mode ? p3_fall[PPM_BIT_EXTERNAL_IRQ_ZERO]
                                                            : ~p3_sync_q[PPM_BIT_EXTERNAL_IRQ_ZERO]);
      uart0_rx_pin      <= p3_sync_q[PPM_BIT_RX];
    end
  end

endmodule
`default_nettype wire

// [ppm_board.sv]
// board model: resolves one port's pin levels from device drive, pull-ups and test drive
`default_nettype none
`timescale 1ns/100ps
module ppm_board (
  // clock
  input  wire logic       clk,
  // device side
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pull,
  // board drive
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  // resolved level
  output var  logic [7:0] pin
);
  // =====================================================
  // line resolution
  // an undriven, unpulled line toggles so a design that reads it cannot match by luck
  logic [7:0] float_q;
  always_ff @(posedge clk) begin
    float_q <= ~pin;
  end
  always_comb begin
    pin = (oe & out) | (~oe & drv_en & drv_val) | (~oe & ~drv_en & pull)
        | (~oe & ~drv_en & ~pull & float_q);
  end
endmodule
`default_nettype wire

// [ppm_port_ctrl_chk.sv]
// concurrent checks on the ports of the port pin mode block
`default_nettype none
`timescale 1ns/100ps
module ppm_chk
  import ppm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_b,
  // register access
  input wire logic [7:0]       sfr_addr,
  input wire logic             sfr_wr,
  input wire logic [7:0]       sfr_wdata,
  input wire logic             sfr_rd,
  input wire logic [7:0]       sfr_rdata_q,
  input wire logic             sfr_hit_q,
  // configuration and peers
  input wire logic [15:0]      port3_mode_cfg,
  input wire logic [7:0]       hardware_config_one,
  input wire logic [WIDTH-1:0] ext_addr_high,
  input wire logic             ext_rd_strobe_b,
  input wire logic             ext_wr_strobe_b,
  input wire logic             timer_one_ext_en,
  input wire logic             irq_one_en,
  input wire logic             irq_one_edge_mode,
  input wire logic             timer_one_count_input,
  input wire logic             external_irq_one,
  // pins
  input wire logic [WIDTH-1:0] port3_pin_in,
  input wire logic [WIDTH-1:0] port2_pin_out_q,
  input wire logic [WIDTH-1:0] port2_pin_oe_q,
  input wire logic [WIDTH-1:0] port3_pin_out_q,
  input wire logic [WIDTH-1:0] port3_pin_oe_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic hit = sfr_addr inside {PPM_ADDR_P1_MODE_LOW, PPM_ADDR_P1_MODE_HIGH,
                                    PPM_ADDR_P3_LATCH, PPM_ADDR_P2_MODE_LOW,
                                    PPM_ADDR_P2_MODE_HIGH};
  // =====================================================
  // sequences
  sequence s_clear_bit2;
    sfr_wr && sfr_addr == PPM_ADDR_P3_LATCH && !sfr_wdata[2]
      && port3_mode_cfg[5:4] != PPM_MODE_INPUT;
  endsequence
  sequence s_mem_hold;
    (hardware_config_one[1] && $stable(ext_rd_strobe_b) && $stable(ext_wr_strobe_b))[*4];
  endsequence
  // =====================================================
  // assertions
  chk_read_hit: assert property (sfr_rd |=> sfr_hit_q == $past(hit))
    else $error("hit flag wrong");
  chk_unmapped_zero: assert property (sfr_rd && !hit |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property (!sfr_rd |=> sfr_rdata_q == 8'h00 && !sfr_hit_q)
    else $error("read data without request");
  chk_latch_drive: assert property (s_clear_bit2 ##1 !sfr_wr |-> ##1
    (port3_pin_oe_q[2] && !port3_pin_out_q[2]))
    else $error("latch zero not driven low");
  chk_rd_strobe: assert property (s_mem_hold |->
    port3_pin_oe_q[7] && port3_pin_out_q[7] == ext_rd_strobe_b)
    else $error("read strobe not on pin");
  chk_wr_strobe: assert property (s_mem_hold |->
    port3_pin_oe_q[6] && port3_pin_out_q[6] == ext_wr_strobe_b)
    else $error("write strobe not on pin");
  chk_port2_mem: assert property ((hardware_config_one[1] && $stable(ext_addr_high))[*4] |->
    port2_pin_oe_q == '1 && port2_pin_out_q == ext_addr_high)
    else $error("port2 not given to memory");
  chk_count_pulse: assert property (timer_one_count_input |=> !timer_one_count_input)
    else $error("count pulse too long");
  chk_count_off: assert property ((!timer_one_ext_en)[*3] |-> !timer_one_count_input)
    else $error("count while disabled");
  chk_irq_level: assert property ((irq_one_en && !irq_one_edge_mode && !port3_pin_in[3])[*5]
    |-> external_irq_one)
    else $error("level interrupt missing");
  chk_irq_off: assert property ((!irq_one_en)[*3] |-> !external_irq_one)
    else $error("interrupt while disabled");
endmodule
bind ppm_port_ctrl ppm_chk #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the port pin mode block
`default_nettype none
`timescale 1ns/100ps
module tb_top;
  // =====================================================
  // signals
  logic clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, ext_rd_strobe_b = 1, ext_wr_strobe_b = 1;
  logic timer_one_ext_en = 0, timer_zero_ext_en = 0, irq_one_en = 0, irq_zero_en = 0;
  logic irq_one_edge_mode = 1, irq_zero_edge_mode = 1, uart0_mode0 = 0, uart0_tx_data = 1;
  logic uart0_shift_clk = 1, uart0_rx_drive = 1, ext_program_select_pin_b = 1;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, port1_data = 8'hFF, port2_data = 8'hFF;
  logic [7:0] hardware_config_one = 0, ext_addr_high = 0, drv_en = 0, drv_val = 0;
  logic [15:0] port3_mode_cfg = 0;
  logic sfr_hit_q, timer_one_count_input, timer_zero_count_input;
  logic external_irq_one, external_irq_zero, uart0_rx_pin;
  logic [7:0] sfr_rdata_q, port1_pin_in, port2_pin_in, port3_pin_in, port1_level_q;
  logic [7:0] port2_level_q, port1_pin_out_q, port1_pin_oe_q, port1_pull_q, port2_pin_out_q;
  logic [7:0] port2_pin_oe_q, port2_pull_q, port3_pin_out_q, port3_pin_oe_q, port3_pull_q;
  // index order matches cnt: irq zero, irq one, timer zero, timer one, receive low
  wire logic [4:0] evt = {~uart0_rx_pin, timer_one_count_input, timer_zero_count_input,
                          external_irq_one, external_irq_zero};
  int checked = 0, miscompares = 0, cnt[5];
  logic [7:0] ra[4] = '{8'hAE, 8'hAF, 8'hB1, 8'hB2};
  always #2.5 clk = ~clk;
  ppm_port_ctrl uut (.*);
  ppm_board b1 (.clk, .out(port1_pin_out_q), .oe(port1_pin_oe_q), .pull(port1_pull_q),
                .drv_en(8'h00), .drv_val(8'h00), .pin(port1_pin_in));
  ppm_board b2 (.clk, .out(port2_pin_out_q), .oe(port2_pin_oe_q), .pull(port2_pull_q),
                .drv_en(8'h00), .drv_val(8'h00), .pin(port2_pin_in));
  ppm_board b3 (.clk, .out(port3_pin_out_q), .oe(port3_pin_oe_q), .pull(port3_pull_q),
                .drv_en(drv_en), .drv_val(drv_val), .pin(port3_pin_in));
  // =====================================================
  // tasks
  task automatic ck(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1;
    @(posedge clk);
    sfr_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1;
    @(posedge clk);
    sfr_rd <= 0;
    #1 ck(sfr_rdata_q, e);
  endtask
  // board pulls pin b low for w cycles while design events are counted
  task automatic fall(input int b, input int w);
    cnt = '{default: 0};
    @(posedge clk);
    drv_en[b] <= 1;
    for (int k = 0; k < w + 8; k++) begin
      @(posedge clk);
      if (k == w - 1) drv_en[b] <= 0;
      #1;
      for (int i = 0; i < 5; i++) cnt[i] += evt[i];
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    rd(8'hB0, 8'hFF);
    rd(8'hB5, 8'h00);
    for (int i = 0; i < 4; i++) rd(ra[i], 8'h00);
    for (int i = 0; i < 4; i++) wr(ra[i], ~ra[i]);
    for (int i = 0; i < 4; i++) rd(ra[i], ~ra[i]);
    // pin3 input, pin2 open drain, pin1 push-pull, pin0 pull-up
    wr(8'hAE, 8'hE4);
    port1_data <= 8'h00;
    at(4);
    ck(8'(port1_pin_oe_q[3:0]), 8'h07);
    @(posedge clk);
    port1_data <= 8'hFF;
    at(6);
    ck(8'(port1_pin_oe_q[3:0]), 8'h02);
    ck(8'(port1_pull_q[3:0]), 8'h01);
    ck(8'(port1_level_q[1:0]), 8'h03);
    ck(port1_pin_out_q, 8'hFF);
    ck(port2_pull_q, 8'h44);
    ck(port2_level_q & 8'hDC, 8'hDC);
    for (int e = 1; e >= 0; e--) begin
      timer_one_ext_en <= e;
      timer_zero_ext_en <= e;
      irq_one_en <= e;
      irq_zero_en <= e;
      for (int b = 2; b < 6; b++) begin
        fall(b, 6);
        for (int i = 0; i < 4; i++) ck(8'(cnt[i]), 8'(e && i == b - 2));
      end
    end
    irq_one_en <= 1;
    irq_zero_en <= 1;
    irq_one_edge_mode <= 0;
    irq_zero_edge_mode <= 0;
    for (int b = 2; b < 4; b++) begin
      fall(b, 8);
      ck(8'(cnt[b - 2]), 8'd8);
    end
    fall(0, 6);
    ck(8'(cnt[4]), 8'd6);
    wr(8'hB0, 8'hFB);
    at(2);
    ck(8'({port3_pin_oe_q[2], port3_pin_out_q[2]}), 8'h02);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      uart0_mode0 <= i[1];
      uart0_tx_data <= i[0];
      uart0_shift_clk <= ~i[0];
      uart0_rx_drive <= i[0];
      at(3);
      ck(8'(port3_pin_out_q[1]), 8'(i[1] ^ i[0]));
      ck(8'(port3_pin_out_q[0]), 8'(i[0] | !i[1]));
    end
    wr(8'hB0, 8'hF9);
    at(3);
    ck(8'(port3_pin_out_q[1]), 8'h00);
    // strobe pins set to input mode with latch zero: memory use must still win
    port3_mode_cfg <= 16'hF000;
    wr(8'hB0, 8'h3F);
    ext_addr_high <= 8'h5A;
    hardware_config_one <= 8'h02;
    ext_rd_strobe_b <= 0;
    at(5);
    ck(port2_pin_oe_q, 8'hFF);
    ck(port2_pin_out_q, 8'h5A);
    ck(8'({port3_pin_oe_q[7:6], port3_pin_out_q[7:6]}), 8'h0D);
    @(posedge clk);
    hardware_config_one <= 8'h00;
    ext_program_select_pin_b <= 0;
    ext_addr_high <= 8'hA5;
    at(6);
    ck(port2_pin_out_q, 8'hA5);
    @(posedge clk);
    ext_program_select_pin_b <= 1;
    at(6);
    ck(8'(port3_pin_oe_q[7:6]), 8'h00);
    ck(port3_pull_q, 8'h3F);
    test_done();
  end
endmodule
`default_nettype wire
